// *** design/txd_params.svh ***
/*
 * Register offsets, field positions and reset values of the transmitter
 * driver configuration bank.
 * Assumes it is included by bare name from design files.
 */
`ifndef TXD_PARAMS_SVH
`define TXD_PARAMS_SVH

// Register offsets (byte addresses of the 8-bit host port)
`define TXD_OFS_DRIVER_MODE 8'h28
`define TXD_OFS_CARRIER_AMPLITUDE 8'h29
`define TXD_OFS_TRANSMIT_CONTROL 8'h2a
`define TXD_OFS_TRANSMIT_CURRENT_TRIM 8'h2b

// Driver mode fields
`define TXD_DM_SECOND_INV_BIT 7
`define TXD_DM_FIRST_INV_BIT 6
`define TXD_DM_ENABLE_BIT 3
`define TXD_DM_CLK_MODE_MSB 2
`define TXD_DM_CLK_MODE_LSB 0
// Writable bits of driver mode; bits 5 and 4 reserved
`define TXD_DM_WRITE_MASK 8'hcf

// Carrier amplitude fields
`define TXD_AMP_REDUCTION_MSB 7
`define TXD_AMP_REDUCTION_LSB 6
`define TXD_AMP_RESIDUAL_MSB 4
`define TXD_AMP_RESIDUAL_LSB 0
// Writable bits of carrier amplitude; bit 5 reserved
`define TXD_AMP_WRITE_MASK 8'hdf

// Transmit control fields
`define TXD_TC_OVERSHOOT_MSB 7
`define TXD_TC_OVERSHOOT_LSB 4
`define TXD_TC_CW_MAX_BIT 3
`define TXD_TC_MOD_INV_BIT 2
`define TXD_TC_MOD_SRC_MSB 1
`define TXD_TC_MOD_SRC_LSB 0

// Transmit current trim fields
`define TXD_TI_OVERSHOOT_FIRST_MSB 7
`define TXD_TI_OVERSHOOT_FIRST_LSB 4
`define TXD_TI_LOAD_TRIM_MSB 3
`define TXD_TI_LOAD_TRIM_LSB 0

// Reset values
`define TXD_RST_DRIVER_MODE 8'h00
`define TXD_RST_CARRIER_AMPLITUDE 8'h00
`define TXD_RST_TRANSMIT_CONTROL 8'h00
`define TXD_RST_TRANSMIT_CURRENT_TRIM 8'h00

// Amplitude code meaning full carrier (no reduction applied)
`define TXD_AMP_MAXIMUM 3'h4

`endif

// *** design/txd_pkg.sv ***
/*
 * Types of the transmitter driver configuration bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package txd_pkg;

	// Output style of the driver pins
	typedef enum logic [2:0] {
		TXD_CLK_OPEN_DRAIN = 3'h0,
		TXD_CLK_PUSH_PULL = 3'h1,
		TXD_CLK_HIGH_Z = 3'h2,
		TXD_CLK_UNSUP_A = 3'h3,
		TXD_CLK_FIX_HIGH = 3'h4,
		TXD_CLK_FIX_LOW = 3'h5,
		TXD_CLK_UNSUP_B = 3'h6,
		TXD_CLK_RESERVED = 3'h7
	} txd_clk_mode_e;

	// Modulation sources
	typedef enum logic [1:0] {
		TXD_SRC_NONE = 2'h0,
		TXD_SRC_ENVELOPE = 2'h1,
		TXD_SRC_EXTERNAL = 2'h2,
		TXD_SRC_RESERVED = 2'h3
	} txd_mod_src_e;

	// Host register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} txd_bus_req_s;

	// Configuration handed to the analog driver and modulation path
	typedef struct packed {
		logic first_output_invert;
		logic second_output_invert;
		logic driver_pins_enable;
		logic [2:0] driver_clock_mode;
		logic mode_unsupported;
		logic [2:0] amplitude_reduction;
		logic [4:0] residual_carrier;
		logic [3:0] overshoot_length;
		logic [3:0] overshoot_first_value;
		logic [3:0] load_current_trim;
	} txd_drv_cfg_s;

endpackage

// *** design/txd_config_regs.sv ***
/*
 * Transmitter driver configuration register bank with its modulation
 * source selection and a plain digital model of the two driver pins.
 * Assumes a host port on clk_sys_i with one-cycle strobes, an external
 * serial modulation input from a pin and an envelope from local logic.
 * The analog driver takes cfg_o as levels; carrier timing, overshoot
 * timers and the load trim itself are handled on the analog side.
 */
`timescale 1ns/100ps
// Behaviour
// (RULE1) Bit 7 inverts second driver pin
// (RULE2) Bit 6 inverts first driver pin
// (RULE3) Bit 3 enables both driver pins
// (RULE4) Three-bit field selects driver output style
// (RULE5) Bits 7:6 choose one of four reductions
// (RULE6) Bits 4:0 set residual carrier percentage
// (RULE7) Carrier maximum bit overrides amplitude reduction
// (RULE8) Bits 7:4 give overshoot modulation length
// (RULE9) Bit 2 inverts selected modulation signal
// (RULE10) Source: none, envelope, external, reserved
// (RULE11) Trim bits 7:4 hold first overshoot value
// (RULE12) Trim bits 3:0 hold load current trim
// (RULE13) Reserved bits read zero, ignore writes
// (RULE14) Writes reach outputs on next edge; cfg_o does, but modulation_o and the driver pins follow one edge later
`include "txd_params.svh"

module txd_config_regs (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire txd_pkg::txd_bus_req_s bus_i,
	output logic [7:0] rdata_o,
	input wire logic transmit_envelope_i,
	input wire logic external_signal_input_i,
	output txd_pkg::txd_drv_cfg_s cfg_o,
	output logic modulation_o,
	output logic first_driver_pin_o,
	output logic second_driver_pin_o
);
	import txd_pkg::*;

	// Stored register contents
	logic [7:0] driver_mode;
	logic [7:0] carrier_amplitude;
	logic [7:0] transmit_control;
	logic [7:0] transmit_current_trim;
	// External input synchroniser stages
	logic ext_meta;
	logic ext_sync;
	// Modulation chosen before inversion
	logic next_modulation;
	// Modulation after the optional inversion, shared by pins and output
	logic next_mod_inv;

	// Address match for a write strobe; shared by every register process
	// and by the assertions so that all of them decode the same way
	function automatic logic hit(input txd_bus_req_s r, input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	// Driver mode register, reserved bits masked off
	// Masking at write time keeps the reserved bits zero for readback
	// and for the field decode alike, so no read-side mask is needed
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			driver_mode <= `TXD_RST_DRIVER_MODE;
		end else if (hit(bus_i, `TXD_OFS_DRIVER_MODE)) begin
			driver_mode <= bus_i.wdata & `TXD_DM_WRITE_MASK; // see (RULE13) (RULE14)
		end
	end

	// Carrier amplitude register, bit 5 masked off
	// Reduction and residual carrier share this byte
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			carrier_amplitude <= `TXD_RST_CARRIER_AMPLITUDE;
		end else if (hit(bus_i, `TXD_OFS_CARRIER_AMPLITUDE)) begin
			carrier_amplitude <= bus_i.wdata & `TXD_AMP_WRITE_MASK; // see (RULE13)
		end
	end

	// Transmit control register
	// Every bit is writable: overshoot, carrier max, inversion, source
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			transmit_control <= `TXD_RST_TRANSMIT_CONTROL;
		end else if (hit(bus_i, `TXD_OFS_TRANSMIT_CONTROL)) begin
			transmit_control <= bus_i.wdata; // see (RULE14)
		end
	end

	// Transmit current trim register
	// Holds the first overshoot value and the load current trim
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			transmit_current_trim <= `TXD_RST_TRANSMIT_CURRENT_TRIM;
		end else if (hit(bus_i, `TXD_OFS_TRANSMIT_CURRENT_TRIM)) begin
			transmit_current_trim <= bus_i.wdata; // see (RULE14)
		end
	end

	// Read data, one cycle after the read strobe; unmapped reads zero
	// Zero outside the answer cycle so stale data never lingers
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
		end else if (bus_i.rd) begin
			case (bus_i.addr)
				`TXD_OFS_DRIVER_MODE: rdata_o <= driver_mode;
				`TXD_OFS_CARRIER_AMPLITUDE: rdata_o <= carrier_amplitude;
				`TXD_OFS_TRANSMIT_CONTROL: rdata_o <= transmit_control;
				`TXD_OFS_TRANSMIT_CURRENT_TRIM: begin
					rdata_o <= transmit_current_trim;
				end
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Field decode toward the analog driver
	// Register fields wired through, apart from the unsupported flag and the carrier maximum override; the clock mode code passes raw
	always_comb begin
		cfg_o.second_output_invert = driver_mode[`TXD_DM_SECOND_INV_BIT]; // see (RULE1)
		cfg_o.first_output_invert = driver_mode[`TXD_DM_FIRST_INV_BIT]; // see (RULE2)
		cfg_o.driver_pins_enable = driver_mode[`TXD_DM_ENABLE_BIT]; // see (RULE3)
		cfg_o.driver_clock_mode =
			driver_mode[`TXD_DM_CLK_MODE_MSB:`TXD_DM_CLK_MODE_LSB]; // see (RULE4)
		// Flag the two unsupported codes for the analog side
		case (txd_clk_mode_e'(cfg_o.driver_clock_mode))
			TXD_CLK_UNSUP_A, TXD_CLK_UNSUP_B: begin
				cfg_o.mode_unsupported = 1'b1; // see (RULE4)
			end
			default: cfg_o.mode_unsupported = 1'b0;
		endcase
		// Carrier maximum overrides the reduction code
		if (transmit_control[`TXD_TC_CW_MAX_BIT]) begin
			cfg_o.amplitude_reduction = `TXD_AMP_MAXIMUM; // see (RULE7)
		end else begin
			cfg_o.amplitude_reduction = {1'b0, carrier_amplitude[
				`TXD_AMP_REDUCTION_MSB:`TXD_AMP_REDUCTION_LSB]}; // see (RULE5)
		end
		cfg_o.residual_carrier = carrier_amplitude[
			`TXD_AMP_RESIDUAL_MSB:`TXD_AMP_RESIDUAL_LSB]; // see (RULE6)
		cfg_o.overshoot_length = transmit_control[
			`TXD_TC_OVERSHOOT_MSB:`TXD_TC_OVERSHOOT_LSB]; // see (RULE8)
		cfg_o.overshoot_first_value = transmit_current_trim[
			`TXD_TI_OVERSHOOT_FIRST_MSB:`TXD_TI_OVERSHOOT_FIRST_LSB]; // see (RULE11)
		cfg_o.load_current_trim = transmit_current_trim[
			`TXD_TI_LOAD_TRIM_MSB:`TXD_TI_LOAD_TRIM_LSB]; // see (RULE12)
	end

	// Two-stage synchroniser for the external serial input pin
	// Only the second stage is read, the first may be metastable
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= external_signal_input_i;
			ext_sync <= ext_meta;
		end
	end

	// Source selection
	// The reserved source code acts as no modulation, so a stray write
	// cannot key the carrier from an undefined signal
	always_comb begin
		case (txd_mod_src_e'(transmit_control[
				`TXD_TC_MOD_SRC_MSB:`TXD_TC_MOD_SRC_LSB]))
			TXD_SRC_ENVELOPE: begin
				// Envelope from local framing logic, same clock
				next_modulation = transmit_envelope_i; // see (RULE10)
			end
			TXD_SRC_EXTERNAL: begin
				// Serial pin, taken after its synchroniser
				next_modulation = ext_sync; // see (RULE10)
			end
			default: begin
				// No modulation and the reserved code
				next_modulation = 1'b0; // see (RULE10)
			end
		endcase
		// Inversion applies after the source choice
		next_mod_inv = next_modulation ^
			transmit_control[`TXD_TC_MOD_INV_BIT]; // see (RULE9)
	end

	// Registered modulation toward the analog modulator
	// Flopping it keeps glitches of the source multiplexer off the path
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			// Quiet carrier while in reset
			modulation_o <= 1'b0;
		end else begin
			modulation_o <= next_mod_inv; // see (RULE9)
		end
	end

	// Driver pin levels: modulation with per-pin inversion, both pins
	// gated by the one enable bit so they switch on and off together
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			// Both pins idle low while in reset
			first_driver_pin_o <= 1'b0;
			second_driver_pin_o <= 1'b0;
		end else begin
			// First pin, own inversion, common enable
			first_driver_pin_o <= (next_mod_inv ^
				cfg_o.first_output_invert) &
				cfg_o.driver_pins_enable; // see (RULE2) (RULE3)
			// Second pin, own inversion, common enable
			second_driver_pin_o <= (next_mod_inv ^
				cfg_o.second_output_invert) &
				cfg_o.driver_pins_enable; // see (RULE1) (RULE3)
		end
	end

	// Assertions
	// Reserved bits never hold a one
	AST_RESERVED_DM: assert property ( // see (RULE13)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		driver_mode[5:4] == 2'h0)
		else $error("driver mode reserved set");
	AST_RESERVED_AMP: assert property ( // see (RULE13)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		carrier_amplitude[5] == 1'b0)
		else $error("amp reserved set");
	// A write reaches the decoded fields on the next edge
	AST_WRITE_DM: assert property ( // see (RULE3)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		hit(bus_i, `TXD_OFS_DRIVER_MODE) |=>
		cfg_o.driver_pins_enable == $past(bus_i.wdata[3]))
		else $error("enable not updated");
	AST_WRITE_TC: assert property ( // see (RULE8)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		hit(bus_i, `TXD_OFS_TRANSMIT_CONTROL) |=>
		cfg_o.overshoot_length == $past(bus_i.wdata[7:4]))
		else $error("overshoot not updated");
	AST_WRITE_AMP: assert property ( // see (RULE6)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		hit(bus_i, `TXD_OFS_CARRIER_AMPLITUDE) |=>
		cfg_o.residual_carrier == $past(bus_i.wdata[4:0]))
		else $error("residual carrier not updated");
	AST_WRITE_T1: assert property ( // see (RULE11)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		hit(bus_i, `TXD_OFS_TRANSMIT_CURRENT_TRIM) |=>
		cfg_o.overshoot_first_value == $past(bus_i.wdata[7:4]))
		else $error("first overshoot not updated");
	AST_WRITE_TRIM: assert property ( // see (RULE12)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		hit(bus_i, `TXD_OFS_TRANSMIT_CURRENT_TRIM) |=>
		cfg_o.load_current_trim == $past(bus_i.wdata[3:0]))
		else $error("load trim not updated");
	// Carrier maximum overrides, otherwise the reduction code passes
	AST_CWMAX: assert property ( // see (RULE7)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		transmit_control[3] |-> cfg_o.amplitude_reduction == 3'h4)
		else $error("cw max ignored");
	AST_REDUCTION: assert property ( // see (RULE5)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!transmit_control[3] |-> cfg_o.amplitude_reduction[1:0] ==
		carrier_amplitude[7:6])
		else $error("reduction wrong");
	// Modulation sources and inversion, one flop behind the choice
	AST_SRC_NONE: assert property ( // see (RULE9)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		transmit_control[1:0] == 2'h0 && $stable(transmit_control) |=>
		modulation_o == $past(transmit_control[2]))
		else $error("none src");
	AST_SRC_ENV: assert property ( // see (RULE10)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		transmit_control[1:0] == 2'h1 |=> modulation_o ==
		($past(transmit_envelope_i) ^ $past(transmit_control[2])))
		else $error("envelope src");
	AST_SRC_EXT: assert property ( // see (RULE10)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		transmit_control[1:0] == 2'h2 |=> modulation_o ==
		($past(ext_sync) ^ $past(transmit_control[2])))
		else $error("external src");
	// Readback of the trim register
	AST_READBACK: assert property ( // see (RULE12)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		bus_i.rd && bus_i.addr == `TXD_OFS_TRANSMIT_CURRENT_TRIM |=>
		rdata_o == $past(transmit_current_trim))
		else $error("readback");
	// Pins follow the enable and their own inversion
	AST_PIN2_OFF: assert property ( // see (RULE3)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!driver_mode[3] |=> !second_driver_pin_o)
		else $error("pin2 on");
	AST_PIN1_OFF: assert property ( // see (RULE3)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		!driver_mode[3] |=> !first_driver_pin_o)
		else $error("pin1 on");
	AST_PIN1_LEVEL: assert property ( // see (RULE2)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		driver_mode[3] |=>
		first_driver_pin_o == (modulation_o ^ $past(driver_mode[6])))
		else $error("pin1 level");
	AST_PIN2_LEVEL: assert property ( // see (RULE1)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		driver_mode[3] |=>
		second_driver_pin_o == (modulation_o ^ $past(driver_mode[7])))
		else $error("pin2 level");
	// Both unsupported clock mode codes are flagged
	AST_UNSUP: assert property ( // see (RULE4)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		driver_mode[2:0] == 3'h6 |-> cfg_o.mode_unsupported)
		else $error("unsupported code missed");
	AST_UNSUP_LOW: assert property ( // see (RULE4)
		@(posedge clk_sys_i) disable iff (!resetn_i)
		driver_mode[2:0] == 3'h3 |-> cfg_o.mode_unsupported)
		else $error("unsupported code missed");

	// Main scenarios reached
	COV_CWMAX: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		hit(bus_i, `TXD_OFS_TRANSMIT_CONTROL) && bus_i.wdata[3]);
	COV_EXT: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		transmit_control[1:0] == 2'h2 && modulation_o);
	COV_READ: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		bus_i.rd ##1 rdata_o != 8'h00);
	COV_UNSUP: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		cfg_o.mode_unsupported);
	COV_PIN_ON: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		first_driver_pin_o && driver_mode[3]);

endmodule

// *** dv/txd_far_model.sv ***
/*
 * Far-side model: envelope source and external serial pin feeding the
 * driver configuration bank.
 * Assumes the bench commands the levels and shares clk_sys_i.
 */
`timescale 1ns/100ps
module txd_far_model (
	input wire logic clk_sys_i,
	input wire logic env_cmd_i,
	input wire logic ext_cmd_i,
	output logic transmit_envelope_o,
	output logic external_signal_input_o
);
	// Envelope comes from local framing logic on the system clock
	always_ff @(posedge clk_sys_i) begin
		transmit_envelope_o <= env_cmd_i;
	end

	// External pin moves off the clock grid, like an unsynchronised source
	assign #3 external_signal_input_o = ext_cmd_i;
endmodule

// *** dv/test_tx_driver_config_regs.sv ***
/*
 * Self-checking bench of the transmitter driver configuration bank.
 * Assumes txd_pkg, txd_config_regs and txd_far_model are compiled first.
 */
`timescale 1ns/100ps
module test_tx_driver_config_regs;
	import txd_pkg::*;
	logic clk_sys_i, resetn_i, env, ext, s, m, e, p1, p2;
	txd_bus_req_s bus; // Host request
	logic [7:0] rdata;
	txd_drv_cfg_s cfg;
	logic mod_o, pin1, pin2, envl, extl;
	int failures, n_tests;

	txd_config_regs u_txd_config_regs (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.bus_i(bus),
		.rdata_o(rdata),
		.transmit_envelope_i(envl),
		.external_signal_input_i(extl),
		.cfg_o(cfg),
		.modulation_o(mod_o),
		.first_driver_pin_o(pin1),
		.second_driver_pin_o(pin2)
	);

	txd_far_model u_txd_far_model (
		.clk_sys_i(clk_sys_i),
		.env_cmd_i(env),
		.ext_cmd_i(ext),
		.transmit_envelope_o(envl),
		.external_signal_input_o(extl)
	);

	// 125 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// Compare one byte and count it
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys_i);
		bus.wr <= 1'b0;
		#1;
	endtask

	// One-cycle read strobe, data checked in the following cycle
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys_i);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// Report and end the run
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		resetn_i = 1'b0;
		bus = '0;
		env = 1'b0;
		ext = 1'b0;
		failures = 0;
		n_tests = 0;
		repeat (20) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		// Reset values
		for (int i = 0; i < 4; i++) begin
			rd(8'h28 + i[7:0], 8'h00);
		end
		wr(8'h28, 8'hff);
		chk({cfg[26:21], 2'b00}, 8'hfc);
		rd(8'h28, 8'hcf);
		wr(8'h29, 8'hff);
		rd(8'h29, 8'hdf);
		// Every clock mode code, unsupported ones flagged
		for (int i = 0; i < 8; i++) begin
			wr(8'h28, i[7:0]);
			s = (i == 3) || (i == 6);
			chk({4'h0, cfg[23:20]}, {4'h0, i[2:0], s});
		end
		// Each amplitude reduction with a residual carrier value
		for (int k = 0; k < 4; k++) begin
			wr(8'h29, {k[1:0], 1'b0, 5'h11 + k[4:0]});
			chk(cfg[19:12], {k[2:0], 5'h11 + k[4:0]});
		end
		wr(8'h2a, 8'ha8);
		chk({cfg[19:17], 1'b0, cfg[11:8]}, 8'h8a);
		rd(8'h2a, 8'ha8);
		wr(8'h2b, 8'h5c);
		chk(cfg[7:0], 8'h5c);
		// Unmapped place ignored, read data drops after one cycle
		wr(8'h2c, 8'h77);
		rd(8'h2c, 8'h00);
		rd(8'h2b, 8'h5c);
		@(posedge clk_sys_i);
		#1 chk(rdata, 8'h00);
		// All sources, inversion, both input levels and pin options
		for (int c = 0; c < 16; c++) begin
			wr(8'h2a, {5'h00, c[2:0]});
			wr(8'h28, {c[3], ~c[3], 2'b00, c[0] ^ c[1], 3'h1});
			@(posedge clk_sys_i);
			env <= c[3];
			ext <= ~c[3];
			repeat (6) @(posedge clk_sys_i);
			#1;
			s = (c[1:0] == 1) ? c[3] : (c[1:0] == 2) ? ~c[3] : 1'b0;
			m = s ^ c[2];
			e = c[0] ^ c[1];
			p1 = (m ^ ~c[3]) & e;
			p2 = (m ^ c[3]) & e;
			chk({7'h0, mod_o}, {7'h0, m});
			chk({6'h0, pin1, pin2}, {6'h0, p1, p2});
		end
		give_verdict();
	end
endmodule
